/* shared/can_accept_pkg.sv */
// Purpose: Shared constants and carriers for the CAN acceptance filter/mask register block
// Assumes: Byte-wide host register port, one 200 MHz clock
// Notes:   Offsets are the byte addresses seen by the host controller
package can_accept_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_FILTERS = 6;
  localparam int NUM_MASKS   = 2;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] FILTER0_EXT_ID_LOW = 8'h03;
  localparam logic [7:0] FILTER1_EXT_ID_LOW = 8'h07;
  localparam logic [7:0] FILTER2_EXT_ID_LOW = 8'h0b;
  localparam logic [7:0] FILTER3_EXT_ID_LOW = 8'h13;
  localparam logic [7:0] FILTER4_EXT_ID_LOW = 8'h17;
  localparam logic [7:0] FILTER5_EXT_ID_LOW = 8'h1b;
  localparam logic [7:0] MASK0_STD_ID_HIGH  = 8'h20;
  localparam logic [7:0] MASK0_STD_ID_LOW   = 8'h21;
  localparam logic [7:0] MASK1_STD_ID_HIGH  = 8'h24;
  localparam logic [7:0] MASK1_STD_ID_LOW   = 8'h25;

  localparam logic [7:0] FILTER_OFFSET [NUM_FILTERS] = '{
    FILTER0_EXT_ID_LOW, FILTER1_EXT_ID_LOW, FILTER2_EXT_ID_LOW,
    FILTER3_EXT_ID_LOW, FILTER4_EXT_ID_LOW, FILTER5_EXT_ID_LOW};
  localparam logic [7:0] MASK_HIGH_OFFSET [NUM_MASKS] = '{MASK0_STD_ID_HIGH, MASK1_STD_ID_HIGH};
  localparam logic [7:0] MASK_LOW_OFFSET  [NUM_MASKS] = '{MASK0_STD_ID_LOW, MASK1_STD_ID_LOW};

  // ****************************************
  // Reset values and field layout
  // ****************************************
  localparam logic [7:0] FILTER_LOW_RESET = 8'h00;  // Power-on content is unknown; zero is chosen
  localparam logic [7:0] MASK_HIGH_RESET  = 8'h00;
  localparam logic [7:0] MASK_LOW_RESET   = 8'h00;
  localparam logic [7:0] MASK_LOW_WRITABLE = 8'he3; // Bits 4..2 unimplemented
  localparam int MASK_LOW_SID_LSB = 5;                // Standard id bits 2..0 at 7..5
  localparam int MASK_LOW_EID_MSB = 1;                // Extended id bits 17..16 at 1..0
  localparam logic [1:0] MASK_SELECT_DATA = 2'h0;     // Buffer mask-select code enabling data compare
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic        ext;    // Received frame carries an extended identifier
    logic [10:0] standard_identifier_bits;
    logic [17:0] extended_identifier_bits;
    logic [7:0]  data0;
    logic [7:0]  data1;
  } frame_t;

  typedef struct packed {
    logic        filter_extended_frame_enable;
    logic [10:0] standard_identifier_bits;
    logic [17:8] eid_upper;
  } filter_ref_t;

  typedef struct packed {
    logic [7:0] eid_mid;   // Mask for extended id bits 15..8
    logic [7:0] eid_low;   // Mask for extended id bits 7..0
  } mask_ext_t;

endpackage

/* rtl/accept_filter_compare.sv */
// Purpose: One acceptance filter compare against one received frame
// Assumes: Mask bit zero means do not care
// Notes:   Purely combinational; the parent registers the outcome
`timescale 1ns/100ps
`default_nettype none
module accept_filter_compare (
  // Frame and buffer mode
  input  wire can_accept_pkg::frame_t      frame,
  input  wire logic [1:0]                  buffer_mask_select_field,
  // Filter reference
  input  wire can_accept_pkg::filter_ref_t filter_ref,
  input  wire logic [7:0]                  filter_ext_id_low,
  // Mask
  input  wire logic [7:0]                  mask_std_id_high,
  input  wire logic [7:0]                  mask_std_id_low,
  input  wire can_accept_pkg::mask_ext_t   mask_ext,
  // Outcome
  output logic                             match
);

  logic [10:0] sid_mask;
  logic [17:0] eid_mask;
  logic [17:0] eid_filt;
  logic        sid_ok;
  logic        eid_ok;
  logic        data_ok;

  // Assemble masks and reference values
  assign sid_mask = {mask_std_id_high, mask_std_id_low[7:can_accept_pkg::MASK_LOW_SID_LSB]};
  assign eid_mask = {mask_std_id_low[can_accept_pkg::MASK_LOW_EID_MSB:0], mask_ext.eid_mid, mask_ext.eid_low};
  assign eid_filt = {filter_ref.eid_upper, filter_ext_id_low};  // Low byte vs id bits 7..0

  // A bit passes when masked off or equal
  assign sid_ok  = ~|(sid_mask & (frame.standard_identifier_bits ^ filter_ref.standard_identifier_bits));
  assign eid_ok  = ~|(eid_mask & (frame.extended_identifier_bits ^ eid_filt));
  assign data_ok = ~|(eid_mask[15:0] & ({frame.data0, frame.data1} ^ eid_filt[15:0]));

  // Filter extended enable selects which fields count
  always_comb begin
    if (filter_ref.filter_extended_frame_enable) begin
      match = frame.ext && sid_ok && eid_ok;
    end else begin
      match = !frame.ext && sid_ok &&
              ((buffer_mask_select_field != can_accept_pkg::MASK_SELECT_DATA) || data_ok);
    end
  end

endmodule
`default_nettype wire

/* rtl/can_accept_filter_mask_regs.sv */
// Purpose: Acceptance filter low-id bytes, mask standard-id bytes, and filter hit selection
// Assumes: Host byte port synchronous to mclk; mode level from the mode controller
// Notes:   Other filter and mask bytes arrive as inputs from their own register blocks
//
// Contract
// - Filter low byte is reference for extended identifier bits 7..0.
// - With mask-select 00 and standard filter, low byte compares data byte 1.
// - Outside Configuration mode, mask and filter reads return zero.
// - Mask high byte masks standard id bits 10..3; zero at power-on.
// - Mask low bits 4..2 read zero; writes there ignored.
// - Mask and filter writes accepted only in Configuration mode.
// - Extended enable one: extended frames only; zero: standard frames only.
// - Lowest-numbered matching filter wins; frame goes to one buffer.
`timescale 1ns/100ps
`default_nettype none
module can_accept_filter_mask_regs #(
  parameter int NUM_FILTERS = can_accept_pkg::NUM_FILTERS,
  parameter int NUM_MASKS   = can_accept_pkg::NUM_MASKS
) (
  // Clock and reset
  input  wire logic                        mclk,
  input  wire logic                        rst_b,
  // Mode
  input  wire logic                        config_mode,
  // Host register port
  input  wire logic [7:0]                  reg_addr,
  input  wire logic                        reg_wr,
  input  wire logic [7:0]                  reg_wdata,
  input  wire logic                        reg_rd,
  output logic [7:0]                       reg_rdata,
  // Received frame
  input  wire logic                        frame_valid,
  input  wire can_accept_pkg::frame_t      frame,
  input  wire logic [1:0]                  buffer_mask_select_field [NUM_MASKS],
  // Companion filter and mask bytes
  input  wire can_accept_pkg::filter_ref_t filter_ref [NUM_FILTERS],
  input  wire can_accept_pkg::mask_ext_t   mask_ext [NUM_MASKS],
  // Register contents to the compare logic
  output logic [7:0]                       filter_ext_id_low [NUM_FILTERS],
  output logic [7:0]                       mask_std_id_high [NUM_MASKS],
  output logic [7:0]                       mask_std_id_low [NUM_MASKS],
  // Filter hit result
  output logic                             hit_valid,
  output logic [2:0]                       matched_filter_code,
  output logic                             hit_buffer
);

  // ****************************************
  // Address decode
  // ****************************************
  logic [NUM_FILTERS-1:0] sel_filter;
  logic [NUM_MASKS-1:0]   sel_mask_high;
  logic [NUM_MASKS-1:0]   sel_mask_low;
  logic                   wr_ok;

  // Writes are only honoured in Configuration mode
  assign wr_ok = reg_wr && config_mode;

  always_comb begin
    for (int f = 0; f < NUM_FILTERS; f++) begin
      sel_filter[f] = (reg_addr == can_accept_pkg::FILTER_OFFSET[f]);
    end
    for (int m = 0; m < NUM_MASKS; m++) begin
      sel_mask_high[m] = (reg_addr == can_accept_pkg::MASK_HIGH_OFFSET[m]);
      sel_mask_low[m]  = (reg_addr == can_accept_pkg::MASK_LOW_OFFSET[m]);
    end
  end

  // ****************************************
  // Register storage
  // ****************************************
  // Filter low identifier bytes
  always_ff @(posedge mclk) begin
    for (int f = 0; f < NUM_FILTERS; f++) begin
      if (!rst_b) begin
        filter_ext_id_low[f] <= can_accept_pkg::FILTER_LOW_RESET;
      end else if (wr_ok && sel_filter[f]) begin
        filter_ext_id_low[f] <= reg_wdata;
      end
    end
  end

  // Mask standard-id bytes; unimplemented low bits never store a one
  always_ff @(posedge mclk) begin
    for (int m = 0; m < NUM_MASKS; m++) begin
      if (!rst_b) begin
        mask_std_id_high[m] <= can_accept_pkg::MASK_HIGH_RESET;
        mask_std_id_low[m]  <= can_accept_pkg::MASK_LOW_RESET;
      end else begin
        if (wr_ok && sel_mask_high[m]) begin
          mask_std_id_high[m] <= reg_wdata;
        end
        if (wr_ok && sel_mask_low[m]) begin
          mask_std_id_low[m] <= reg_wdata & can_accept_pkg::MASK_LOW_WRITABLE;
        end
      end
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  logic [7:0] next_rdata;

  // Any other address in this block reads zero; so does every read outside Configuration mode
  always_comb begin
    next_rdata = can_accept_pkg::READ_ZERO;
    for (int f = 0; f < NUM_FILTERS; f++) begin
      if (sel_filter[f]) begin
        next_rdata = filter_ext_id_low[f];
      end
    end
    for (int m = 0; m < NUM_MASKS; m++) begin
      if (sel_mask_high[m]) begin
        next_rdata = mask_std_id_high[m];
      end
      if (sel_mask_low[m]) begin
        next_rdata = mask_std_id_low[m];
      end
    end
    if (!config_mode) begin
      next_rdata = can_accept_pkg::READ_ZERO;
    end
  end

  // Read data registered one cycle after the strobe and held until the next read
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      reg_rdata <= can_accept_pkg::READ_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // ****************************************
  // Filter compare
  // ****************************************
  logic [NUM_FILTERS-1:0] match;

  // Filters 0 and 1 use mask 0 and buffer 0; the rest use mask 1 and buffer 1
  genvar g;
  generate
    for (g = 0; g < NUM_FILTERS; g++) begin : gen_cmp
      localparam int MI = (g < 2) ? 0 : 1;
      accept_filter_compare u_cmp (
        .frame                    (frame),
        .buffer_mask_select_field (buffer_mask_select_field[MI]),
        .filter_ref               (filter_ref[g]),
        .filter_ext_id_low        (filter_ext_id_low[g]),
        .mask_std_id_high         (mask_std_id_high[MI]),
        .mask_std_id_low          (mask_std_id_low[MI]),
        .mask_ext                 (mask_ext[MI]),
        .match                    (match[g])
      );
    end
  endgenerate

  // ****************************************
  // Priority and result
  // ****************************************
  logic [2:0] next_code;

  // Descending scan so the lowest-numbered match is the one left standing
  always_comb begin
    next_code = 3'h0;
    for (int f = NUM_FILTERS - 1; f >= 0; f--) begin
      if (match[f]) begin
        next_code = f[2:0];
      end
    end
  end

  // One result per frame; a single code means a single buffer
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      hit_valid           <= 1'b0;
      matched_filter_code <= 3'h0;
      hit_buffer          <= 1'b0;
    end else begin
      hit_valid <= frame_valid && (|match);
      if (frame_valid && (|match)) begin
        matched_filter_code <= next_code;
        hit_buffer          <= (next_code >= 3'h2);
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  a_read_zero_outside: assert property (reg_rd && !config_mode |=> reg_rdata == 8'h00)
    else $error("Register read returned data outside Configuration mode");
  a_write_blocked: assert property (reg_wr && !config_mode && sel_filter[2]
                                    |=> filter_ext_id_low[2] == $past(filter_ext_id_low[2]))
    else $error("Filter byte changed by a write outside Configuration mode");
  a_write_taken: assert property (reg_wr && config_mode && sel_mask_high[1]
                                  |=> mask_std_id_high[1] == $past(reg_wdata))
    else $error("Mask high byte did not take a Configuration write");
  a_mask_unimpl_zero: assert property (reg_rd && config_mode && sel_mask_low[0] |=> reg_rdata[4:2] == 3'h0)
    else $error("Unimplemented mask bits read back non-zero");
  a_mask_low_store: assert property (wr_ok && sel_mask_low[0] |=> mask_std_id_low[0][4:2] == 3'h0)
    else $error("Unimplemented mask bits stored a one");
  a_mask_reset_zero: assert property ($rose(rst_b) |-> mask_std_id_high[0] == 8'h00 && mask_std_id_low[1] == 8'h00)
    else $error("Mask bytes not cleared by reset");
  a_eid_low_compare: assert property (frame.ext && filter_ref[0].filter_extended_frame_enable
                                      && |(mask_ext[0].eid_low & (frame.extended_identifier_bits[7:0] ^ filter_ext_id_low[0]))
                                      |-> !match[0])
    else $error("Filter passed a frame differing in masked low id bits");
  a_data_byte_compare: assert property (!frame.ext && !filter_ref[1].filter_extended_frame_enable
                                        && buffer_mask_select_field[0] == 2'h0
                                        && |(mask_ext[0].eid_low & (frame.data1 ^ filter_ext_id_low[1]))
                                        |-> !match[1])
    else $error("Filter passed a frame differing in masked data byte 1");
  a_frame_type_gate: assert property (frame.ext != filter_ref[1].filter_extended_frame_enable |-> !match[1])
    else $error("Filter matched a frame of the wrong identifier type");
  a_lowest_wins: assert property (frame_valid && match[0] |=> hit_valid && matched_filter_code == 3'h0 && !hit_buffer)
    else $error("Filter 0 match not reported with priority");
  a_one_buffer: assert property (frame_valid && match[2:0] == 3'h4 |=> hit_buffer && matched_filter_code == 3'h2)
    else $error("Filter 2 match sent to wrong buffer");
  a_code_holds: assert property (frame_valid && !(|match) |=> $stable(matched_filter_code) && $stable(hit_buffer))
    else $error("Filter code changed without a match");
  a_no_hit_quiet: assert property (frame_valid && match == 6'h00 |=> !hit_valid)
    else $error("Hit reported with no matching filter");

  c_config_write: cover property (reg_wr && config_mode && sel_mask_low[0]);
  c_blocked_read: cover property (reg_rd && !config_mode && sel_filter[3]);
  c_multi_match: cover property (frame_valid && match[2] && match[4]);
  c_data_filter: cover property (frame_valid && match[1] && !frame.ext && buffer_mask_select_field[0] == 2'h0);

endmodule
`default_nettype wire

/* test/host_model.sv */
// Purpose: Host controller model that reaches the acceptance registers byte by byte
// Assumes: One-cycle write and read strobes; read data valid one edge after the strobe
// Notes:   Write data is inverted after each write so a stale byte is never mistaken for a live one
`timescale 1ns/100ps
`default_nettype none
module host_model (
  // Clock
  input  wire logic       mclk,
  // Register port towards the device
  output logic [7:0]      reg_addr,
  output logic            reg_wr,
  output logic [7:0]      reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  // Idle levels at time zero
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    reg_rd    = 1'b0;
  end

  // One byte write, strobe held for exactly one sampling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d; // Released data must not keep showing the old byte
  endtask

  // One byte read, data taken after the edge that follows the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
endmodule
`default_nettype wire

/* test/can_accept_filter_mask_regs_tb.sv */
// Purpose: Self-checking bench for the acceptance filter and mask register block
// Assumes: Companion filter and mask bytes are driven directly by the bench
// Notes:   Frames are single-cycle pulses; hit result is looked at one edge later
`timescale 1ns/100ps
`default_nettype none
module can_accept_filter_mask_regs_tb;
  // ****************************************
  // Signals
  // ****************************************
  logic                        mclk = 1'b0;
  logic                        rst_b = 1'b0;
  logic                        config_mode = 1'b1;
  logic [7:0]                  reg_addr, reg_wdata, reg_rdata;
  logic                        reg_wr, reg_rd;
  logic                        frame_valid = 1'b0;
  can_accept_pkg::frame_t      frame = '0;
  logic [1:0]                  sel [2] = '{2'h1, 2'h1};
  can_accept_pkg::filter_ref_t fref [6];
  can_accept_pkg::mask_ext_t   mext [2] = '{16'h00_ff, 16'h00_ff};
  logic [7:0]                  flow [6], mhigh [2], mlow [2];
  logic                        hit_valid, hit_buffer;
  logic [2:0]                  code;
  int                          num_errors = 0;
  int                          samples_checked = 0;
  logic [7:0]                  rv;

  // Half-period of 2.5 ns gives 200 MHz
  always #2.5 mclk = ~mclk;

  initial foreach (fref[i]) fref[i] = {1'b1, 11'h000, 10'h000};

  host_model host (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
                   .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  can_accept_filter_mask_regs dut (
    .mclk(mclk), .rst_b(rst_b), .config_mode(config_mode), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_valid(frame_valid),
    .frame(frame), .buffer_mask_select_field(sel), .filter_ref(fref), .mask_ext(mext),
    .filter_ext_id_low(flow), .mask_std_id_high(mhigh), .mask_std_id_low(mlow),
    .hit_valid(hit_valid), .matched_filter_code(code), .hit_buffer(hit_buffer));

  // ****************************************
  // Compare and closing tasks
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // One frame pulse, then the registered hit result
  task automatic send(input can_accept_pkg::frame_t f, input logic hv, input logic [2:0] c, input logic b);
    @(posedge mclk);
    frame       <= f;
    frame_valid <= 1'b1;
    @(posedge mclk);
    frame_valid <= 1'b0;
    #1;
    chk({7'h0, hit_valid}, {7'h0, hv});
    chk({5'h0, code}, {5'h0, c});
    chk({7'h0, hit_buffer}, {7'h0, b});
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  // Power-on contents of the mask bytes
  task automatic t_reset();
    host.rd(can_accept_pkg::MASK0_STD_ID_HIGH, rv);
    chk(rv, 8'h00);
    host.rd(can_accept_pkg::MASK1_STD_ID_LOW, rv);
    chk(rv, 8'h00);
  endtask

  // Full writes in Configuration mode; unimplemented mask bits stay zero
  task automatic t_write();
    for (int m = 0; m < 2; m++) begin
      host.wr(can_accept_pkg::MASK_HIGH_OFFSET[m], 8'hff);
      host.wr(can_accept_pkg::MASK_LOW_OFFSET[m], 8'hff);
      host.rd(can_accept_pkg::MASK_LOW_OFFSET[m], rv);
      chk(rv, 8'he3);
      chk(mhigh[m], 8'hff);
      chk(mlow[m], 8'he3);
    end
    for (int i = 0; i < 6; i++) begin
      host.wr(can_accept_pkg::FILTER_OFFSET[i], 8'h11 * (i + 1));
      #1;
      chk(flow[i], 8'h11 * (i + 1));
    end
  endtask

  // Outside Configuration mode: reads give zero, writes are dropped
  task automatic t_mode();
    @(posedge mclk);
    config_mode <= 1'b0;
    host.rd(can_accept_pkg::MASK0_STD_ID_HIGH, rv);
    chk(rv, 8'h00);
    host.rd(can_accept_pkg::FILTER2_EXT_ID_LOW, rv);
    chk(rv, 8'h00);
    host.wr(can_accept_pkg::FILTER2_EXT_ID_LOW, 8'h00);
    config_mode <= 1'b1;
    host.rd(can_accept_pkg::FILTER2_EXT_ID_LOW, rv);
    chk(rv, 8'h33);
    host.rd(8'h30, rv);
    chk(rv, 8'h00);
  endtask

  // Extended id low byte matching, priority and frame type restriction
  task automatic t_frames();
    host.wr(can_accept_pkg::FILTER4_EXT_ID_LOW, 8'h33);
    send({1'b1, 11'h000, 18'h0_0033, 16'h0000}, 1'b1, 3'h2, 1'b1);
    send({1'b1, 11'h000, 18'h0_0034, 16'h0000}, 1'b0, 3'h2, 1'b1);
    send({1'b0, 11'h000, 18'h0_0033, 16'h0000}, 1'b0, 3'h2, 1'b1);
    send({1'b1, 11'h000, 18'h0_0011, 16'h0000}, 1'b1, 3'h0, 1'b0);
    // Standard filter 1 with data compare on the second data byte only
    @(posedge mclk);
    fref[1] <= {1'b0, 11'h000, 10'h000};
    sel[0]  <= can_accept_pkg::MASK_SELECT_DATA;
    send({1'b0, 11'h000, 18'h0_0000, 16'h5a22}, 1'b1, 3'h1, 1'b0);
    send({1'b0, 11'h000, 18'h0_0000, 16'h0023}, 1'b0, 3'h1, 1'b0);
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset();
    t_write();
    t_mode();
    t_frames();
    give_verdict();
  end

  // Whole run is under a hundred cycles; far longer means a hang
  initial begin
    #20000;
    num_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
